// file: pd_aeq_pkg.sv
// Constants for the pin pull-down and equalizer wait register slice.
// Assumes register access arrives already decoded from the serial bus.
`default_nettype none
package pd_aeq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PIN_COUNT = 8;
  localparam int WAIT_W = 23;
  localparam int CLK_PERIOD_NS = 5;

  // Register offsets
  localparam logic [7:0] PIN_PULLDOWN_DISABLE_OFS = 8'hbe;
  localparam logic [7:0] PORT_DEBUG_STATUS_OFS = 8'hd0;
  localparam logic [7:0] EQUALIZER_TEST_CONTROL_OFS = 8'hd2;

  // Field positions
  localparam int REMOTE_SELFTEST_BIT = 5;
  localparam int DEBUG_SPARE_HI_BIT = 6;
  localparam int STEP_WAIT_LSB = 5;
  localparam int STEP_WAIT_W = 3;

  // Reset values and debug write mask
  localparam logic [7:0] PULLDOWN_DISABLE_RST = 8'h00;
  localparam logic [7:0] PORT_DEBUG_RST = 8'h00;
  localparam logic [2:0] STEP_WAIT_RST = 3'h4;
  localparam logic [7:0] DEBUG_WRITE_MASK = 8'h5f;

  // Equalizer wait times in ns, one per code
  localparam longint STEP_WAIT_NS [8] = '{
    164000, 328000, 655000, 1310000,
    2620000, 5240000, 10500000, 21000000
  };

  // Each wait rounds up to whole cycles
  function automatic logic [WAIT_W-1:0] wait_cycles(input int code);
    longint cyc;
    cyc = (STEP_WAIT_NS[code] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return cyc[WAIT_W-1:0];
  endfunction

  localparam logic [7:0][WAIT_W-1:0] STEP_WAIT_CYCLES = {
    wait_cycles(7), wait_cycles(6), wait_cycles(5), wait_cycles(4),
    wait_cycles(3), wait_cycles(2), wait_cycles(1), wait_cycles(0)
  };
endpackage
`default_nettype wire

// file: eq_step_timer.sv
// Wait timer pacing the adaptive equalizer between settings.
// Assumes search_in stays high while the receiver hunts for lock.
`timescale 1ns/1ps
`default_nettype none
module eq_step_timer #(
  parameter int WAIT_W = 23
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Control
  input wire logic search_in,
  input wire logic [WAIT_W-1:0] wait_cycles_in,
  // Result
  output logic step_out
);
  logic [WAIT_W-1:0] count;
  wire logic at_limit;

  // Compare with >= so a shortened setting mid-wait still ends it
  assign at_limit = (count + WAIT_W'(1)) >= wait_cycles_in;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
      step_out <= 1'b0;
    end else if (!search_in) begin
      count <= '0;
      step_out <= 1'b0;
    end else if (at_limit) begin
      count <= '0;
      step_out <= 1'b1;
    end else begin
      count <= count + WAIT_W'(1);
      step_out <= 1'b0;
    end
  end

  // Helper: cycles of search since the last step or start
  logic [WAIT_W-1:0] elapsed;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      elapsed <= '0;
    end else if (!search_in || step_out) begin
      elapsed <= search_in ? WAIT_W'(1) : '0;
    end else begin
      elapsed <= elapsed + WAIT_W'(1);
    end
  end

  a_step_after_wait: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    step_out |-> $past(search_in) && (elapsed >= $past(wait_cycles_in)))
    else $error("Equalizer step came before the wait elapsed");
endmodule
`default_nettype wire

// file: gpio_pulldown_aeq_cfg.sv
// Pull-down control, remote self-test flag and equalizer wait register.
// Assumes a decoded register port from the serial control bus slave.
`timescale 1ns/1ps
`default_nettype none
module gpio_pulldown_aeq_cfg #(
  parameter logic [7:0][pd_aeq_pkg::WAIT_W-1:0] STEP_WAIT_CYCLES =
    pd_aeq_pkg::STEP_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [pd_aeq_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [pd_aeq_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [pd_aeq_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Pins
  input wire logic [pd_aeq_pkg::PIN_COUNT-1:0] pin_output_mode_in,
  output logic [pd_aeq_pkg::PIN_COUNT-1:0] pin_pulldown_en_out,
  // Link and equalizer
  input wire logic remote_selftest_in,
  input wire logic eq_search_in,
  output logic eq_step_out
);
  import pd_aeq_pkg::*;

  logic [7:0] pin_pulldown_disable;
  logic [7:0] port_debug_spare;
  logic remote_selftest_active;
  logic [2:0] equalizer_step_wait;

  wire logic hit_pd;
  wire logic hit_dbg;
  wire logic hit_eq;
  wire logic [7:0] port_debug_status;
  wire logic [7:0] eq_test_read;
  wire logic [7:0] read_mux;
  wire logic [WAIT_W-1:0] wait_now;

  assign hit_pd = reg_addr_in == PIN_PULLDOWN_DISABLE_OFS;
  assign hit_dbg = reg_addr_in == PORT_DEBUG_STATUS_OFS;
  assign hit_eq = reg_addr_in == EQUALIZER_TEST_CONTROL_OFS;

  // Bit 7 reads zero, bit 5 is status, the rest are spare storage
  assign port_debug_status = (port_debug_spare & DEBUG_WRITE_MASK) |
    (8'(remote_selftest_active) << REMOTE_SELFTEST_BIT);
  // Other equalizer test fields live elsewhere and read zero here
  assign eq_test_read = 8'(equalizer_step_wait) << STEP_WAIT_LSB;
  assign read_mux = hit_pd ? pin_pulldown_disable :
    hit_dbg ? port_debug_status :
    hit_eq ? eq_test_read : 8'h00;

  // Pull-down only where the pin is not driving and not disabled
  assign pin_pulldown_en_out =
    ~pin_output_mode_in & ~pin_pulldown_disable;

  assign wait_now = STEP_WAIT_CYCLES[equalizer_step_wait];

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_pulldown_disable <= PULLDOWN_DISABLE_RST;
      port_debug_spare <= PORT_DEBUG_RST;
      equalizer_step_wait <= STEP_WAIT_RST;
    end else if (reg_wr_in) begin
      if (hit_pd) begin
        pin_pulldown_disable <= reg_wdata_in;
      end
      if (hit_dbg) begin
        port_debug_spare <= reg_wdata_in & DEBUG_WRITE_MASK;
      end
      if (hit_eq) begin
        equalizer_step_wait <=
          reg_wdata_in[STEP_WAIT_LSB +: STEP_WAIT_W];
      end
    end
  end

  // Status follows the link every cycle; software cannot write it
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      remote_selftest_active <= 1'b0;
    end else begin
      remote_selftest_active <= remote_selftest_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= read_mux;
      end
    end
  end

  eq_step_timer #(
    .WAIT_W(WAIT_W)
  ) u_step_timer (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .search_in(eq_search_in),
    .wait_cycles_in(wait_now),
    .step_out(eq_step_out)
  );

  // Helper: has software ever written the pull-down disable and equalizer registers
  logic pd_written;
  logic eq_written;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pd_written <= 1'b0;
      eq_written <= 1'b0;
    end else begin
      pd_written <= pd_written | (reg_wr_in & hit_pd);
      eq_written <= eq_written | (reg_wr_in & hit_eq);
    end
  end

  sequence s_pd_write;
    reg_wr_in && hit_pd && !reg_rd_in;
  endsequence

  sequence s_pd_read_back;
    reg_rd_in && hit_pd ##1 reg_rvalid_out;
  endsequence

  sequence s_dbg_write;
    reg_wr_in && hit_dbg;
  endsequence

  sequence s_eq_write;
    reg_wr_in && hit_eq;
  endsequence

  // No antecedent, so any mix of output pins is covered
  a_output_no_pulldown: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (pin_pulldown_en_out & pin_output_mode_in) == 8'h00)
    else $error("Pull-down on a pin in output mode");

  a_input_pulldown_on: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (~pin_output_mode_in & ~pin_pulldown_disable &
      ~pin_pulldown_en_out) == 8'h00)
    else $error("Pull-down missing on an enabled input pin");

  a_disable_keeps_off: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (pin_pulldown_en_out & pin_pulldown_disable) == 8'h00)
    else $error("Pull-down on a pin whose disable bit is set");

  a_disable_bit_holds: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_pd_write ##1 pin_output_mode_in == 8'h00 |->
      pin_pulldown_en_out == ~$past(reg_wdata_in))
    else $error("Pull-down does not follow the written disable bits");

  a_pd_write_lands: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_pd_write |=> pin_pulldown_disable == $past(reg_wdata_in))
    else $error("Disable register write did not land");

  a_disable_read_back: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_pd_write ##1 s_pd_read_back |->
      reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("Disable register reads back a wrong value");

  // Same-cycle write and read still returns the old contents
  a_pd_read_valid: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reg_rd_in && hit_pd |=>
      reg_rvalid_out && reg_rdata_out == $past(pin_pulldown_disable))
    else $error("Disable register read gave a wrong answer");

  a_pulldown_reset: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !pd_written && pin_output_mode_in == 8'h00 |->
      pin_pulldown_en_out == 8'hff)
    else $error("Pull-down not enabled after reset");

  // First edge after release is skipped: the flag was held in reset
  a_selftest_follows: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $past(nrst_in) |-> remote_selftest_active == $past(remote_selftest_in))
    else $error("Self-test flag does not follow the link");

  // Spare storage never holds bits 7 and 5, so writes cannot fake status
  a_status_not_writable: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_dbg_write |=> !port_debug_spare[REMOTE_SELFTEST_BIT] &&
      !port_debug_spare[7])
    else $error("Status bit reached by a register write");

  a_selftest_status: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reg_rd_in && hit_dbg ##1 $past(nrst_in, 2) |->
      reg_rdata_out[REMOTE_SELFTEST_BIT] == $past(remote_selftest_in, 2)
      && !reg_rdata_out[7])
    else $error("Remote self-test flag misreported");

  a_wait_default: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !eq_written |-> wait_now == STEP_WAIT_CYCLES[4])
    else $error("Equalizer wait not at its default");

  a_eq_write_lands: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_eq_write |=> equalizer_step_wait ==
      $past(reg_wdata_in[STEP_WAIT_LSB +: STEP_WAIT_W]))
    else $error("Equalizer wait code write did not land");

  a_eq_read_fields: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reg_rd_in && hit_eq |=> reg_rvalid_out &&
      reg_rdata_out[STEP_WAIT_LSB +: STEP_WAIT_W] ==
      $past(equalizer_step_wait) &&
      reg_rdata_out[STEP_WAIT_LSB-1:0] == '0)
    else $error("Equalizer test register reads back wrong");

  a_no_step_idle: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !eq_search_in |=> !eq_step_out)
    else $error("Equalizer stepped while not searching");
endmodule
`default_nettype wire

// file: remote_ser_model.sv
// Behavioural remote serializer: reports its self-test state.
// Assumes the link delivers the report one clock after the request.
`timescale 1ns/1ps
`default_nettype none
module remote_ser_model (
  // Clock
  input wire logic clk_sys_in,
  // Control from bench
  input wire logic selftest_req_in,
  // Report over the link
  output logic selftest_out
);
  // Report is a level, held while self-test runs
  always_ff @(posedge clk_sys_in) begin
    selftest_out <= selftest_req_in;
  end
endmodule
`default_nettype wire

// file: gpio_pulldown_aeq_cfg_tb_top.sv
// Self-checking bench for the pull-down and equalizer wait registers.
// Assumes the decoded strobe port of the design and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module gpio_pulldown_aeq_cfg_tb_top;
  import pd_aeq_pkg::*;
  // Short waits keep the run brief: code c waits c+4 cycles
  function automatic logic [7:0][WAIT_W-1:0] short_waits();
    for (int i = 0; i < 8; i++) begin
      short_waits[i] = WAIT_W'(i + 4);
    end
  endfunction
  function automatic logic [16:0] next_rand(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic search = 1'b0;
  logic st_req = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] mode = 8'h00;
  logic [7:0] rdata;
  logic [7:0] pden;
  logic rvalid;
  logic selftest;
  logic step;
  logic [16:0] seed = 17'h1_009c;
  int mismatches = 0;
  int n_tests = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  gpio_pulldown_aeq_cfg #(.STEP_WAIT_CYCLES(short_waits())) dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .pin_output_mode_in(mode), .pin_pulldown_en_out(pden),
    .remote_selftest_in(selftest), .eq_search_in(search),
    .eq_step_out(step));
  remote_ser_model ser (.clk_sys_in(clk_sys_in),
    .selftest_req_in(st_req), .selftest_out(selftest));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_in);
    rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
    // Idle edge so a following read never reassigns rd in this step
    @(negedge clk_sys_in);
  endtask
  task automatic final_report();
    $display("Compares %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    int k;
    logic [7:0] d;
    repeat (8) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    @(negedge clk_sys_in);
    reg_read(PIN_PULLDOWN_DISABLE_OFS, 8'h00);
    reg_read(PORT_DEBUG_STATUS_OFS, 8'h00);
    reg_read(EQUALIZER_TEST_CONTROL_OFS, 8'h80);
    reg_read(8'hbf, 8'h00);
    $display("Test reset values done");
    // All-on and all-off corners first, then random mixes
    for (int i = 0; i < 20; i++) begin
      seed = next_rand(seed);
      d = seed[7:0];
      mode = seed[15:8];
      if (i < 2) begin
        d = {8{i[0]}};
        mode = 8'h00;
      end
      reg_write(PIN_PULLDOWN_DISABLE_OFS, d);
      check(pden, ~mode & ~d);
      reg_read(PIN_PULLDOWN_DISABLE_OFS, d);
    end
    reg_write(8'hbd, 8'h5a);
    reg_read(PIN_PULLDOWN_DISABLE_OFS, d);
    $display("Test pull-down control done");
    reg_write(PORT_DEBUG_STATUS_OFS, 8'hff);
    reg_read(PORT_DEBUG_STATUS_OFS, 8'h5f);
    st_req = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    // Local side is not in self-test, so software sees a suspect flag
    reg_read(PORT_DEBUG_STATUS_OFS, 8'h7f);
    st_req = 1'b0;
    $display("Test self-test flag done");
    for (int c = 0; c < 8; c++) begin
      reg_write(EQUALIZER_TEST_CONTROL_OFS, {c[2:0], 5'h1f});
      reg_read(EQUALIZER_TEST_CONTROL_OFS, {c[2:0], 5'h00});
      search = 1'b1;
      k = 0;
      while (step !== 1'b1 && k < 40) begin
        @(negedge clk_sys_in);
        k++;
      end
      check(8'(k), 8'(c + 4));
      search = 1'b0;
      @(negedge clk_sys_in);
      if (k >= 40) begin
        final_report();
      end
    end
    $display("Test equalizer wait done");
    final_report();
  end
endmodule
`default_nettype wire
